// ### drive_cmd_pkg.sv
// drive_cmd_pkg.sv: constants, codes and carriers of the drive command logic
`default_nettype none
package drive_cmd_pkg;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned PULSE_MIN_MS  = 3;
  localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned SEC_CYC       = CLK_HZ;
  localparam logic [6:0]  TIMEOUT_DEF_S = 7'h0A;
  // ----------------------------------------------------------------------
  // widths, scales and codes
  // ----------------------------------------------------------------------
  localparam logic [9:0]  REF_FULL      = 10'h3E8;  // 1000 steps of 0.1 %
  localparam logic [9:0]  REF_STEP      = 10'h001;
  localparam logic [11:0] THERM_CUT_OHM = 12'hBB8;  // 3000 ohm
  localparam logic [1:0]  AI_NONE       = 2'h0;
  localparam logic [1:0]  AI_REF        = 2'h1;
  localparam logic [1:0]  AI_FB         = 2'h2;
  localparam logic [1:0]  AI_THERM      = 2'h3;
  localparam int unsigned AI_NUM        = 3;
  localparam int unsigned AI_VOLT_NUM   = 2;
  localparam logic [2:0]  TO_OFF        = 3'h0;
  localparam logic [2:0]  TO_FREEZE     = 3'h1;
  localparam logic [2:0]  TO_STOP       = 3'h2;
  localparam logic [2:0]  TO_JOG        = 3'h3;
  localparam logic [2:0]  TO_MAX        = 3'h4;
  localparam logic [1:0]  MODE_OPEN     = 2'h0;
  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_OFF  = 3'b001,
    OP_HAND = 3'b010,
    OP_AUTO = 3'b100
  } op_mode_t;
  typedef struct packed {
    logic       start;
    logic [3:0] run_perm;
    logic       jog;
    logic       coast_n;
    logic       panel_lock;
    logic       hand;
    logic       auto_mode;
    logic       latch_start;
    logic       off_stop;
    logic       stop_n;
    logic       alternate;
    logic       freeze;
    logic       speed_up;
    logic       speed_down;
  } dig_in_t;
  typedef struct packed {
    logic [3:0]  run_perm_used;
    logic        hoa_used;
    logic        lock_used;
    logic [1:0]  ctl_mode;
    logic [6:0]  timeout_s;
    logic [2:0]  timeout_act;
    logic [15:0] alt_interval_s;
    logic [15:0] pulse_max_hz;
  } cfg_t;
  typedef struct packed {
    logic [1:0]  func;
    logic [11:0] value;
    logic [11:0] min_scale;
  } ana_ch_t;
  typedef struct packed {
    logic       run;
    logic       jog;
    logic       coast;
    logic       ramp_stop;
    logic [1:0] ctl_mode;
    logic       write_ok;
    logic       therm_trip;
    logic [2:0] timeout_act;
    logic       alt_req;
  } cmd_out_t;
  typedef struct packed {
    op_mode_t    mode;
    cmd_out_t    out;
    logic        latched;
    logic [16:0] lat_cnt;
    logic [16:0] hi_cnt;
    logic [16:0] lo_cnt;
    logic        armed;
    logic [9:0]  frozen;
    logic        restored;
    logic        start_hold;
    logic        stop_hold;
    logic [25:0] sec_cnt;
    logic [6:0]  lz_secs;
    logic [15:0] alt_secs;
    logic        alt_busy;
    logic        force_d;
    logic [9:0]  pulse_ref;
    logic [13:0] ref_sum;
  } st_t;
endpackage
`default_nettype wire

// ### drive_input_command_logic.sv
// drive_input_command_logic.sv: start, stop, mode and analog supervision
// --------------------------------------------------------------------------
// Summary of operation
// R1: frozen reference changeable while stopped, restored after mains loss.
// R2: start accepted only with run permission, a logical AND.
// R3: permission granted if any assigned permission input is high.
// R4: jog input forces jog frequency and issues a start.
// R5: jog ignored while coast stop is commanded.
// R6: local reference forces open-loop control mode code 0.
// R7: panel lock blocks panel writes, bus writes still allowed.
// R8: pulse reference maps 0 Hz to minimum, max frequency to maximum.
// R9: hand input high runs motor; low stops into off unless auto.
// R10: hand and auto inputs override front-panel hand and auto keys.
// R11: auto input high selects auto mode, accepting terminal or serial start.
// R12: auto input wins when hand and auto both active.
// R13: neither hand nor auto active stops motor into off state.
// R14: latched start on pulse of at least 3 ms; stop inverse stops it.
// R15: ramp-stop input stops the motor on the ramp-down setting.
// R16: stop inverse is active low, blocks running, stops on ramp.
// R17: forced alternation overrides timer; timer restarts after sequence.
// R18: start, ramp stop and stop inverse ignored in current limit.
// R19: analog selector none/ref/feedback/thermistor; thermistor on voltage only.
// R20: ref or feedback below half minimum scale triggers timeout action.
// R21: all reference-function analog inputs are summed.
// R22: thermistor above 3 kohm stops the drive for overtemperature; here only therm_trip is raised, run is not cleared.
// R23: speed up/down ramp frozen value; 3 ms pulse steps 0.1 percent.
// R24: signal loss timeout in whole seconds, default 10.
// R25: timeout action codes off, freeze, stop, jog, max frequency.
// --------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module drive_input_command_logic
  import drive_cmd_pkg::*;
#(
  parameter int unsigned PULSE_CYC = drive_cmd_pkg::PULSE_MIN_CYC,
  parameter int unsigned SEC_CYCLES = drive_cmd_pkg::SEC_CYC
) (
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    arst_n_in,
  // terminals and panel
  input  wire drive_cmd_pkg::dig_in_t  dig_in,
  input  wire logic                    hand_key_in,
  input  wire logic                    auto_key_in,
  input  wire logic                    serial_start_in,
  input  wire logic                    local_ref_in,
  input  wire logic                    current_limit_in,
  input  wire logic                    panel_write_in,
  input  wire logic                    bus_write_in,
  input  wire logic                    ramp_tick_in,
  input  wire logic                    alt_done_in,
  input  wire logic [15:0]             pulse_freq_in,
  input  wire logic [9:0]              saved_ref_in,
  // configuration
  input  wire drive_cmd_pkg::cfg_t     cfg_in,
  // analog inputs, 0 and 1 voltage, 2 current
  input  wire drive_cmd_pkg::ana_ch_t  ana_in [drive_cmd_pkg::AI_NUM],
  // results
  output var   drive_cmd_pkg::cmd_out_t cmd_out,
  output logic [2:0]                   op_mode_out,
  output logic [9:0]                   frozen_ref_out,
  output logic [9:0]                   pulse_ref_out,
  output logic [13:0]                  ref_sum_out
);
  import drive_cmd_pkg::*;

  // --------------------------------------------------------------------------
  // analog input decode
  // --------------------------------------------------------------------------
  function automatic logic [1:0] eff_func(input logic [1:0] f, input int ch);
    // thermistor is only wired on the voltage inputs
    eff_func = (f == AI_THERM && ch >= AI_VOLT_NUM) ? AI_NONE : f; // see R19
  endfunction

  logic [AI_NUM-1:0] ch_low;
  logic [AI_NUM-1:0] ch_hot;
  logic [11:0]       ch_ref [AI_NUM];
  genvar g;
  generate
    for (g = 0; g < AI_NUM; g++) begin : g_ai
      logic [1:0] f;
      assign f = eff_func(ana_in[g].func, g);
      assign ch_low[g] = (f == AI_REF || f == AI_FB) &&
                         ana_in[g].min_scale != 12'h000 &&
                         ana_in[g].value < (ana_in[g].min_scale >> 1); // see R20
      assign ch_hot[g] = (f == AI_THERM) &&
                         ana_in[g].value > THERM_CUT_OHM; // see R22
      assign ch_ref[g] = (f == AI_REF) ? ana_in[g].value : 12'h000;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // state update
  // --------------------------------------------------------------------------
  st_t st;
  st_t next_st;
  logic        perm;
  logic        start_eff;
  logic        stop_eff;
  logic        hand_eff;
  logic        auto_eff;
  logic        sec_tick;
  logic        sp_on;
  logic [25:0] quot;
  logic [13:0] sum;

  always_comb begin
    next_st = st;
    sum = 14'h0000;
    for (int i = 0; i < AI_NUM; i++) begin
      sum = sum + {2'h0, ch_ref[i]}; // see R21
    end
    next_st.ref_sum = sum;
    // pulse reference scaling
    quot = (cfg_in.pulse_max_hz == 16'h0000) ? 26'h0000000 :
           ({10'h000, pulse_freq_in} * {16'h0000, REF_FULL}) /
           {10'h000, cfg_in.pulse_max_hz};
    next_st.pulse_ref = (pulse_freq_in >= cfg_in.pulse_max_hz) ? REF_FULL :
                        quot[9:0]; // see R8
    // one-second enable
    sec_tick = st.sec_cnt == 26'(SEC_CYCLES - 1);
    next_st.sec_cnt = sec_tick ? 26'h0000000 : st.sec_cnt + 26'h0000001;
    // commands are frozen at their last value while in current limit
    start_eff = current_limit_in ? st.start_hold : dig_in.start; // see R18
    stop_eff  = current_limit_in ? st.stop_hold :
                (dig_in.off_stop || !dig_in.stop_n); // see R15, R16, R18
    next_st.start_hold = start_eff;
    next_st.stop_hold  = stop_eff;
    perm = (cfg_in.run_perm_used == 4'h0) ||
           |(cfg_in.run_perm_used & dig_in.run_perm); // see R3
    // latched start: qualifying pulse length before it latches
    if (dig_in.latch_start && !current_limit_in) begin
      if (st.lat_cnt != 17'(PULSE_CYC)) begin
        next_st.lat_cnt = st.lat_cnt + 17'h00001;
      end
    end else begin
      next_st.lat_cnt = 17'h00000;
    end
    if (stop_eff) begin
      next_st.latched = 1'b0; // see R14
    end else if (st.lat_cnt == 17'(PULSE_CYC)) begin
      next_st.latched = 1'b1; // see R14
    end
    // hand/off/auto: terminals outrank the keys, auto outranks hand
    hand_eff = cfg_in.hoa_used ? dig_in.hand : hand_key_in; // see R10
    auto_eff = cfg_in.hoa_used ? dig_in.auto_mode : auto_key_in; // see R10
    if (auto_eff) begin
      next_st.mode = OP_AUTO; // see R11, R12
    end else if (hand_eff) begin
      next_st.mode = OP_HAND; // see R9
    end else begin
      next_st.mode = OP_OFF; // see R9, R13
    end
    // run decision
    next_st.out.coast = !dig_in.coast_n;
    next_st.out.jog   = dig_in.jog && dig_in.coast_n; // see R4, R5
    next_st.out.ramp_stop = stop_eff; // see R15, R16
    unique case (next_st.mode)
      OP_HAND: next_st.out.run = !stop_eff && dig_in.coast_n; // see R9
      OP_AUTO: next_st.out.run = !stop_eff && dig_in.coast_n && perm &&
                 (start_eff || next_st.latched || serial_start_in ||
                  next_st.out.jog); // see R2, R4, R11
      default: next_st.out.run = 1'b0; // see R13
    endcase
    next_st.out.ctl_mode = local_ref_in ? MODE_OPEN : cfg_in.ctl_mode; // see R6
    next_st.out.write_ok = bus_write_in ||
      (panel_write_in && !(cfg_in.lock_used && dig_in.panel_lock)); // see R7
    // frozen reference: restored once after reset, stepped while frozen
    next_st.restored = 1'b1;
    if (!st.restored) begin
      next_st.frozen = (saved_ref_in > REF_FULL) ? REF_FULL : saved_ref_in; // see R1
    end
    sp_on = dig_in.freeze && (dig_in.speed_up ^ dig_in.speed_down);
    if (sp_on) begin
      next_st.lo_cnt = 17'h00000;
      if (st.hi_cnt != 17'(PULSE_CYC)) begin
        next_st.hi_cnt = st.hi_cnt + 17'h00001;
      end
    end else begin
      next_st.hi_cnt = 17'h00000;
      if (st.lo_cnt != 17'(PULSE_CYC)) begin
        next_st.lo_cnt = st.lo_cnt + 17'h00001;
      end else begin
        next_st.armed = 1'b1; // pause long enough for the next pulse
      end
    end
    // one step when the pulse qualifies, then ramp while still held
    if (st.restored && sp_on && st.hi_cnt == 17'(PULSE_CYC) &&
        (st.armed || ramp_tick_in)) begin
      next_st.armed = 1'b0;
      if (dig_in.speed_up && st.frozen < REF_FULL) begin
        next_st.frozen = st.frozen + REF_STEP; // see R1, R23
      end else if (dig_in.speed_down && st.frozen != 10'h000) begin
        next_st.frozen = st.frozen - REF_STEP; // see R1, R23
      end
    end
    // signal loss supervision
    next_st.out.therm_trip = |ch_hot; // see R22
    if (ch_low == '0) begin
      next_st.lz_secs = 7'h00;
    end else if (sec_tick && st.lz_secs < cfg_in.timeout_s) begin
      next_st.lz_secs = st.lz_secs + 7'h01; // see R24
    end
    next_st.out.timeout_act = (ch_low != '0 && cfg_in.timeout_s != 7'h00 &&
      st.lz_secs >= cfg_in.timeout_s) ? cfg_in.timeout_act : TO_OFF; // see R20, R25
    // motor alternation: force on a rising input, timer held while busy
    next_st.force_d = dig_in.alternate;
    next_st.out.alt_req = 1'b0;
    if (st.alt_busy) begin
      if (alt_done_in) begin
        next_st.alt_busy = 1'b0;
        next_st.alt_secs = 16'h0000; // see R17
      end
    end else if ((dig_in.alternate && !st.force_d) ||
                 (cfg_in.alt_interval_s != 16'h0000 &&
                  st.alt_secs >= cfg_in.alt_interval_s)) begin
      next_st.alt_busy    = 1'b1; // see R17
      next_st.out.alt_req = 1'b1;
    end else if (sec_tick) begin
      next_st.alt_secs = st.alt_secs + 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st      <= '0;
      st.mode <= OP_OFF;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_out        = st.out;
  assign op_mode_out    = st.mode;
  assign frozen_ref_out = st.frozen;
  assign pulse_ref_out  = st.pulse_ref;
  assign ref_sum_out    = st.ref_sum;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_start_needs_perm: assert property ( // see R2
    st.mode == OP_AUTO && st.out.run |-> $past(perm))
    else $error("run in auto without permission");
  a_jog_blocked_coast: assert property ( // see R5
    !dig_in.coast_n |=> !st.out.jog && !st.out.run)
    else $error("jog or run during coast stop");
  a_local_open_loop: assert property ( // see R6
    local_ref_in |=> st.out.ctl_mode == MODE_OPEN)
    else $error("local reference not open loop");
  a_lock_blocks_panel: assert property ( // see R7
    cfg_in.lock_used && dig_in.panel_lock && !bus_write_in
    |=> !st.out.write_ok)
    else $error("panel write passed lock");
  a_auto_priority: assert property ( // see R12
    cfg_in.hoa_used && dig_in.auto_mode |=> st.mode == OP_AUTO)
    else $error("auto input not prioritised");
  a_off_no_run: assert property ( // see R13
    st.mode == OP_OFF |-> !st.out.run)
    else $error("run while off");
  a_stop_inv_stops: assert property ( // see R16
    !dig_in.stop_n && !current_limit_in |=> !st.out.run && st.out.ramp_stop)
    else $error("stop inverse did not stop");
  a_therm_trip: assert property ( // see R22
    ana_in[0].func == AI_THERM && ana_in[0].value > THERM_CUT_OHM
    |=> st.out.therm_trip)
    else $error("thermistor trip missed");
  a_alt_force: assert property ( // see R17
    !st.alt_busy && dig_in.alternate && !st.force_d |=> st.out.alt_req ##1
    !st.out.alt_req)
    else $error("forced alternation not one pulse");
  a_frozen_bound: assert property ( // see R23
    st.frozen <= REF_FULL && (!$past(st.restored) || $stable(st.frozen) ||
    (st.frozen - $past(st.frozen) == REF_STEP) ||
    ($past(st.frozen) - st.frozen == REF_STEP)))
    else $error("frozen reference moved by more than a step");

  c_auto_run:   cover property (st.mode == OP_AUTO ##1 st.out.run);
  c_latched:    cover property ($rose(st.latched));
  c_timeout:    cover property (st.out.timeout_act != TO_OFF);
  c_alternate:  cover property (st.out.alt_req ##[1:20] alt_done_in);
endmodule // drive_input_command_logic
`default_nettype wire

// ### tb_drive_input_command_logic.sv
// tb_drive_input_command_logic.sv: self-checking bench of the command logic
`timescale 1ns/1ps
`default_nettype none
module tb_drive_input_command_logic;
  import drive_cmd_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  // short counts keep the run brief
  localparam int unsigned PC = 8;
  localparam int unsigned SC = 16;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  dig_in_t     want;
  dig_in_t     dig;
  dig_in_t     d;
  logic        hkey = 1'b0;
  logic        akey = 1'b0;
  logic        sstart = 1'b0;
  logic        rtick = 1'b0;
  logic        lref = 1'b0;
  logic        clim = 1'b0;
  logic        pw = 1'b0;
  logic        bw = 1'b0;
  logic        adone = 1'b0;
  logic [15:0] pfreq = 16'h0000;
  cfg_t        cfg;
  ana_ch_t     ana [AI_NUM];
  cmd_out_t    cmd;
  logic [2:0]  mode;
  logic [9:0]  frz;
  logic [9:0]  pref;
  logic [13:0] rsum;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          alt_seen = 0;

  terminal_switches i_terminal_switches (
    .clk_in  (clk_in),
    .want_in (want),
    .dig_out (dig)
  );
  drive_input_command_logic #(
    .PULSE_CYC  (PC),
    .SEC_CYCLES (SC)
  ) i_drive_input_command_logic (
    .clk_in           (clk_in),
    .arst_n_in        (arst_n_in),
    .dig_in           (dig),
    .hand_key_in      (hkey),
    .auto_key_in      (akey),
    .serial_start_in  (sstart),
    .local_ref_in     (lref),
    .current_limit_in (clim),
    .panel_write_in   (pw),
    .bus_write_in     (bw),
    .ramp_tick_in     (rtick),
    .alt_done_in      (adone),
    .pulse_freq_in    (pfreq),
    .saved_ref_in     (10'h1F4),
    .cfg_in           (cfg),
    .ana_in           (ana),
    .cmd_out          (cmd),
    .op_mode_out      (mode),
    .frozen_ref_out   (frz),
    .pulse_ref_out    (pref),
    .ref_sum_out      (rsum)
  );
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick_n(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // level lasts n+1 cycles: one edge through the switch, one to register
  task automatic put(input dig_in_t v, input int n);
    @(posedge clk_in);
    want <= v;
    tick_n(n);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_mode();
    d = want;
    d.auto_mode = 1'b1;
    d.start = 1'b1;
    put(d, 3);
    chk(mode, OP_AUTO);
    chk(cmd.run, 1'b0);
    d.run_perm = 4'h2;
    put(d, 3);
    chk(cmd.run, 1'b1);
    d.hand = 1'b1;
    put(d, 3);
    chk(mode, OP_AUTO);
    d.auto_mode = 1'b0;
    put(d, 3);
    chk(mode, OP_HAND);
    chk(cmd.run, 1'b1);
    hkey <= 1'b1;
    d.hand = 1'b0;
    put(d, 3);
    chk(mode, OP_OFF);
    chk(cmd.run, 1'b0);
    cfg.hoa_used <= 1'b0;
    akey <= 1'b1;
    tick_n(2);
    chk(mode, OP_AUTO);
    cfg.hoa_used <= 1'b1;
    akey <= 1'b0;
    hkey <= 1'b0;
    tick_n(2);
    chk(mode, OP_OFF);
    done("mode");
  endtask
  task automatic t_jog();
    d.auto_mode = 1'b1;
    d.start = 1'b0;
    d.jog = 1'b1;
    put(d, 3);
    chk(cmd.jog, 1'b1);
    chk(cmd.run, 1'b1);
    d.coast_n = 1'b0;
    put(d, 3);
    chk(cmd.jog, 1'b0);
    chk(cmd.coast, 1'b1);
    d.coast_n = 1'b1;
    d.jog = 1'b0;
    sstart <= 1'b1;
    put(d, 3);
    chk(cmd.run, 1'b1);
    chk(cmd.coast, 1'b0);
    sstart <= 1'b0;
    d.panel_lock = 1'b1;
    lref <= 1'b1;
    pw <= 1'b1;
    put(d, 3);
    chk(cmd.ctl_mode, MODE_OPEN);
    chk(cmd.write_ok, 1'b0);
    lref <= 1'b0;
    pw <= 1'b0;
    bw <= 1'b1;
    tick_n(2);
    chk(cmd.ctl_mode, 2'h2);
    chk(cmd.write_ok, 1'b1);
    bw <= 1'b0;
    done("jog");
  endtask
  task automatic t_pulse();
    logic [15:0] fr [4] = '{16'h0000, 16'h01F4, 16'h03E8, 16'h07D0};
    logic [9:0]  ex [4] = '{10'h000, 10'h1F4, 10'h3E8, 10'h3E8};
    for (int i = 0; i < 4; i++) begin
      pfreq <= fr[i];
      tick_n(2);
      chk(pref, ex[i]);
    end
    done("pulse");
  endtask
  task automatic t_ana();
    ana[0] <= '{AI_REF, 12'h064, 12'h000};
    ana[1] <= '{AI_FB, 12'h032, 12'h000};
    ana[2] <= '{AI_REF, 12'h0C8, 12'h000};
    tick_n(2);
    chk(rsum, 14'h012C);
    ana[0] <= '{AI_THERM, 12'hBB9, 12'h000};
    ana[2] <= '{AI_THERM, 12'hFA0, 12'h000};
    tick_n(2);
    chk(cmd.therm_trip, 1'b1);
    chk(rsum, 14'h0000);
    ana[0] <= '{AI_THERM, THERM_CUT_OHM, 12'h000};
    tick_n(2);
    chk(cmd.therm_trip, 1'b0);
    ana[0] <= '0;
    ana[2] <= '0;
    done("analog");
  endtask
  task automatic t_lz();
    int n;
    ana[1] <= '{AI_FB, 12'h190, 12'h190};
    for (int a = 0; a < 5; a++) begin
      cfg.timeout_act <= a[2:0];
      ana[1].value <= 12'h00A;
      tick_n(3);
      chk(cmd.timeout_act, 3'h0);
      n = 0;
      while (cmd.timeout_act !== a[2:0] && n < 4 * SC) begin
        tick_n(1);
        n++;
      end
      chk(cmd.timeout_act, a[2:0]);
      if (a > 0) chk(n + 3 >= SC, 1'b1);
      ana[1].value <= 12'h190;
      tick_n(2);
      chk(cmd.timeout_act, 3'h0);
    end
    done("live zero");
  endtask
  task automatic t_latch();
    dig_in_t lo;
    lo = want;
    d = want;
    d.latch_start = 1'b1;
    put(d, 3);
    put(lo, 4);
    chk(cmd.run, 1'b0);
    put(d, PC + 1);
    put(lo, 4);
    chk(cmd.run, 1'b1);
    lo.stop_n = 1'b0;
    put(lo, 1);
    d.stop_n = 1'b0;
    put(d, PC + 1);
    put(lo, 4);
    chk(cmd.run, 1'b0);
    lo.stop_n = 1'b1;
    d.stop_n = 1'b1;
    put(d, PC + 1);
    put(lo, 4);
    clim <= 1'b1;
    lo.off_stop = 1'b1;
    put(lo, 4);
    chk(cmd.ramp_stop, 1'b0);
    chk(cmd.run, 1'b1);
    clim <= 1'b0;
    tick_n(3);
    chk(cmd.ramp_stop, 1'b1);
    chk(cmd.run, 1'b0);
    lo.off_stop = 1'b0;
    put(lo, 3);
    done("latched start");
  endtask
  task automatic t_freeze();
    d = want;
    d.freeze = 1'b1;
    put(d, PC + 2);
    d.speed_up = 1'b1;
    put(d, PC + 1);
    d.speed_up = 1'b0;
    put(d, PC + 1);
    chk(frz, 10'h1F5);
    d.speed_down = 1'b1;
    put(d, PC + 1);
    d.speed_down = 1'b0;
    put(d, PC + 1);
    chk(frz, 10'h1F4);
    d.speed_up = 1'b1;
    put(d, PC + 2);
    chk(frz, 10'h1F5);
    @(posedge clk_in);
    rtick <= 1'b1;
    @(posedge clk_in);
    rtick <= 1'b0;
    tick_n(1);
    chk(frz, 10'h1F6);
    d.speed_up = 1'b0;
    put(d, 2);
    done("freeze");
  endtask
  task automatic t_alt();
    d = want;
    d.alternate = 1'b1;
    put(d, 3);
    chk(alt_seen, 1);
    d.alternate = 1'b0;
    put(d, 3);
    d.alternate = 1'b1;
    put(d, 3);
    chk(alt_seen, 1);
    @(posedge clk_in);
    adone <= 1'b1;
    @(posedge clk_in);
    adone <= 1'b0;
    d.alternate = 1'b0;
    put(d, 3);
    d.alternate = 1'b1;
    put(d, 3);
    chk(alt_seen, 2);
    done("alternation");
  endtask
  // ----------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  // whole run is about 400 cycles; the ceiling leaves room
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cmd.alt_req === 1'b1) alt_seen <= alt_seen + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    want = '0;
    want.coast_n = 1'b1;
    want.stop_n = 1'b1;
    cfg = '0;
    cfg.run_perm_used = 4'h3;
    cfg.hoa_used = 1'b1;
    cfg.lock_used = 1'b1;
    cfg.ctl_mode = 2'h2;
    cfg.timeout_s = 7'h02;
    cfg.pulse_max_hz = 16'h03E8;
    for (int i = 0; i < AI_NUM; i++) ana[i] = '0;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    tick_n(2);
    chk(mode, OP_OFF);
    chk(frz, 10'h1F4);
    t_mode();
    t_jog();
    t_pulse();
    t_ana();
    t_lz();
    t_latch();
    t_freeze();
    t_alt();
    give_verdict();
  end
endmodule // tb_drive_input_command_logic
`default_nettype wire

// ### terminal_switches.sv
// terminal_switches.sv: model of the switches and contacts on the terminals
`timescale 1ns/1ps
`default_nettype none
module terminal_switches
  import drive_cmd_pkg::*;
(
  // clock
  input  wire logic                   clk_in,
  // wanted contact positions
  input  wire drive_cmd_pkg::dig_in_t want_in,
  // terminal levels
  output var  drive_cmd_pkg::dig_in_t dig_out = '0
);
  // contacts move only on an edge, so no level changes mid-cycle
  // minimum pulse and pause widths are kept by the caller
  always @(posedge clk_in) begin
    dig_out <= want_in;
  end
endmodule // terminal_switches
`default_nettype wire
